// *** logic/bmt_consts.svh ***
// register offsets, field positions and reset values of the byte move controller
`ifndef BMT_CONSTS_SVH
`define BMT_CONSTS_SVH

`define BMT_OFF_CTRL 8'h00
`define BMT_OFF_STATUS 8'h04
`define BMT_OFF_IRQ_STATUS 8'h08
`define BMT_OFF_IRQ_MASK 8'h0c
`define BMT_OFF_SRC_START 8'h10
`define BMT_OFF_SRC_TERM_ADDR 8'h14
`define BMT_OFF_SRC_TERM_CHAR 8'h18
`define BMT_OFF_SRC_CUR 8'h1c
`define BMT_OFF_DST_START 8'h20
`define BMT_OFF_DST_TERM_ADDR 8'h24
`define BMT_OFF_DST_TERM_CHAR 8'h28
`define BMT_OFF_DST_CUR 8'h2c

`define BMT_ADDR_W 15
`define BMT_ADDR_ONLY_BIT 15
`define BMT_CTRL_GO_BIT 0
`define BMT_STAT_BUSY_BIT 0
`define BMT_STAT_END_SRC_BIT 1
`define BMT_STAT_END_DST_BIT 2
`define BMT_IRQ_IDLE_BIT 0
`define BMT_IRQ_DONE_BIT 1

`define BMT_RST_ADDR 15'h0000
`define BMT_RST_TERM 16'h0000
`define BMT_RST_CHAR 8'h00
`define BMT_RST_IRQ 2'h0
`define BMT_RESP_OKAY 2'h0
`define BMT_RESP_SLVERR 2'h2

`endif

// *** logic/bmt_pkg.sv ***
// types shared by the byte move controller
package bmt_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_read = 3'b010,
    st_write = 3'b100
  } bmt_state_t;
endpackage

// *** logic/bmt_term_match.sv ***
// termination comparator, one design used for both the source and destination side
`timescale 1ns/10ps
`include "bmt_consts.svh"
module bmt_term_match (
  input wire logic [14:0] cur_addr,
  input wire logic [15:0] term_addr,
  input wire logic [7:0] term_char,
  input wire logic [7:0] data,
  output logic addr_hit,
  output logic char_hit,
  output logic hit
);
  // every one of the 15 bits takes part in the compare
  assign addr_hit = (cur_addr == term_addr[14:0]);
  // full 8-bit compare, no character value is special
  assign char_hit = !term_addr[`BMT_ADDR_ONLY_BIT] && (data == term_char);
  assign hit = addr_hit || char_hit;
endmodule

// *** logic/bmt_move_ctrl.sv ***
// byte string move controller with character/address termination and axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "bmt_consts.svh"

module bmt_move_ctrl (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic mem_rd_req,
  output logic [14:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic [7:0] mem_rd_data,
  output logic mem_wr_req,
  output logic [14:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  input wire logic mem_wr_ack,
  output logic irq
);
  logic rst_meta, rst_n;
  bmt_pkg::bmt_state_t state, next_state;
  logic aw_have, w_have, do_write, wr_mapped, rd_mapped, cmd_go, step_done, end_move;
  logic [7:0] wr_addr_q, src_term_char, dst_term_char, byte_q;
  logic [31:0] wr_data_q, rd_mux;
  logic [3:0] wr_strb_q;
  logic [14:0] src_start, src_cur, dst_start, dst_cur;
  logic [15:0] src_term_addr, dst_term_addr, wr_mask, wr_bits;
  logic end_src, end_dst;
  logic [1:0] irq_status, irq_mask, next_irq_status;
  logic src_hit, dst_hit, src_addr_hit, dst_addr_hit, src_char_hit, dst_char_hit;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // strobes widened to a bit mask; bytes not strobed keep their old value
  assign wr_mask = {{8{wr_strb_q[1]}}, {8{wr_strb_q[0]}}};
  assign wr_bits = wr_data_q[15:0] & wr_mask;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // write channel: address and data taken in either order, response after both
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BMT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        wr_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_have && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_have && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `BMT_RESP_OKAY : `BMT_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign do_write = aw_have && w_have && !s_axi_bvalid;
  // the map is one run of aligned words from ctrl up to the destination current address
  assign wr_mapped = (wr_addr_q <= `BMT_OFF_DST_CUR) && (wr_addr_q[1:0] == 2'h0);

  // move command, ignored while a move is running
  assign cmd_go = do_write && (wr_addr_q == `BMT_OFF_CTRL) && wr_strb_q[0]
                  && wr_data_q[`BMT_CTRL_GO_BIT] && (state == bmt_pkg::st_idle);

  // vectors are frozen during a move so the compare never sees a half-written value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_start <= `BMT_RST_ADDR;
      src_term_addr <= `BMT_RST_TERM;
      src_term_char <= `BMT_RST_CHAR;
      dst_start <= `BMT_RST_ADDR;
      dst_term_addr <= `BMT_RST_TERM;
      dst_term_char <= `BMT_RST_CHAR;
      irq_mask <= `BMT_RST_IRQ;
    end else if (do_write) begin
      if (wr_addr_q == `BMT_OFF_IRQ_MASK) begin
        irq_mask <= (irq_mask & ~wr_mask[1:0]) | wr_bits[1:0];
      end
      if (state == bmt_pkg::st_idle) begin
        case (wr_addr_q)
          `BMT_OFF_SRC_START: src_start <= (src_start & ~wr_mask[14:0]) | wr_bits[14:0];
          `BMT_OFF_SRC_TERM_ADDR: src_term_addr <= (src_term_addr & ~wr_mask) | wr_bits;
          `BMT_OFF_SRC_TERM_CHAR: src_term_char <= (src_term_char & ~wr_mask[7:0]) | wr_bits[7:0];
          `BMT_OFF_DST_START: dst_start <= (dst_start & ~wr_mask[14:0]) | wr_bits[14:0];
          `BMT_OFF_DST_TERM_ADDR: dst_term_addr <= (dst_term_addr & ~wr_mask) | wr_bits;
          `BMT_OFF_DST_TERM_CHAR: dst_term_char <= (dst_term_char & ~wr_mask[7:0]) | wr_bits[7:0];
          default: ;
        endcase
      end
    end
  end

  // read channel: one read at a time, answer one cycle after the address is taken
  always_comb begin
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      `BMT_OFF_CTRL: rd_mux = 32'h0000_0000;
      `BMT_OFF_STATUS: rd_mux = {29'h0, end_dst, end_src, state != bmt_pkg::st_idle};
      `BMT_OFF_IRQ_STATUS: rd_mux = {30'h0, irq_status};
      `BMT_OFF_IRQ_MASK: rd_mux = {30'h0, irq_mask};
      `BMT_OFF_SRC_START: rd_mux = {17'h0, src_start};
      `BMT_OFF_SRC_TERM_ADDR: rd_mux = {16'h0, src_term_addr};
      `BMT_OFF_SRC_TERM_CHAR: rd_mux = {24'h0, src_term_char};
      `BMT_OFF_SRC_CUR: rd_mux = {17'h0, src_cur};
      `BMT_OFF_DST_START: rd_mux = {17'h0, dst_start};
      `BMT_OFF_DST_TERM_ADDR: rd_mux = {16'h0, dst_term_addr};
      `BMT_OFF_DST_TERM_CHAR: rd_mux = {24'h0, dst_term_char};
      `BMT_OFF_DST_CUR: rd_mux = {17'h0, dst_cur};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `BMT_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_mapped ? `BMT_RESP_OKAY : `BMT_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // one comparator design serves both sides
  bmt_term_match u_src_match (
    .cur_addr(src_cur),
    .term_addr(src_term_addr),
    .term_char(src_term_char),
    .data(byte_q),
    .addr_hit(src_addr_hit),
    .char_hit(src_char_hit),
    .hit(src_hit)
  );

  // destination character is matched against the byte taken from the source
  bmt_term_match u_dst_match (
    .cur_addr(dst_cur),
    .term_addr(dst_term_addr),
    .term_char(dst_term_char),
    .data(byte_q),
    .addr_hit(dst_addr_hit),
    .char_hit(dst_char_hit),
    .hit(dst_hit)
  );

  assign step_done = (state == bmt_pkg::st_write) && mem_wr_ack;
  assign end_move = step_done && (src_hit || dst_hit);

  always_comb begin
    next_state = state;
    case (state)
      bmt_pkg::st_idle: begin
        if (cmd_go) begin
          next_state = bmt_pkg::st_read;
        end
      end
      bmt_pkg::st_read: begin
        if (mem_rd_ack) begin
          next_state = bmt_pkg::st_write;
        end
      end
      bmt_pkg::st_write: begin
        if (end_move) begin
          next_state = bmt_pkg::st_idle;
        end else if (mem_wr_ack) begin
          next_state = bmt_pkg::st_read;
        end
      end
      default: next_state = bmt_pkg::st_idle;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= bmt_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // current addresses stay on the byte that ended the move
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_cur <= `BMT_RST_ADDR;
      dst_cur <= `BMT_RST_ADDR;
    end else if (cmd_go) begin
      src_cur <= src_start;
      dst_cur <= dst_start;
    end else if (step_done && !end_move) begin
      src_cur <= src_cur + 15'h0001;
      dst_cur <= dst_cur + 15'h0001;
    end
  end

  // memory side: request held until acknowledged
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rd_req <= 1'b0;
      mem_rd_addr <= `BMT_RST_ADDR;
      mem_wr_req <= 1'b0;
      mem_wr_addr <= `BMT_RST_ADDR;
      mem_wr_data <= 8'h00;
      byte_q <= 8'h00;
    end else begin
      if (cmd_go) begin
        mem_rd_req <= 1'b1;
        mem_rd_addr <= src_start;
      end else if (state == bmt_pkg::st_read && mem_rd_ack) begin
        mem_rd_req <= 1'b0;
        byte_q <= mem_rd_data;
        mem_wr_req <= 1'b1;
        mem_wr_addr <= dst_cur;
        mem_wr_data <= mem_rd_data;
      end else if (step_done) begin
        mem_wr_req <= 1'b0;
        mem_rd_req <= !end_move;
        mem_rd_addr <= src_cur + 15'h0001;
      end
    end
  end

  // which side ended the last move; both may be set
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      end_src <= 1'b0;
      end_dst <= 1'b0;
    end else if (cmd_go) begin
      end_src <= 1'b0;
      end_dst <= 1'b0;
    end else if (end_move) begin
      end_src <= src_hit;
      end_dst <= dst_hit;
    end
  end

  // sticky bits, write one to clear; a set in the same cycle wins
  always_comb begin
    next_irq_status = irq_status;
    if (do_write && wr_addr_q == `BMT_OFF_IRQ_STATUS && wr_strb_q[0]) begin
      next_irq_status = irq_status & ~wr_data_q[1:0];
    end
    if (next_state == bmt_pkg::st_idle) begin
      next_irq_status[`BMT_IRQ_IDLE_BIT] = 1'b1;
    end
    if (end_move) begin
      next_irq_status[`BMT_IRQ_DONE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= `BMT_RST_IRQ;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask) && (next_state == bmt_pkg::st_idle);
    end
  end

  a_cur_load: assert property (cmd_go |=> src_cur == $past(src_start) && dst_cur == $past(dst_start))
    else $error("current addresses not loaded from start");
  a_cmd_starts: assert property (cmd_go |=> state == bmt_pkg::st_read && mem_rd_req && mem_rd_addr == src_cur)
    else $error("move command did not start a read");
  a_no_irq_busy: assert property (state != bmt_pkg::st_idle |-> !irq)
    else $error("interrupt raised during a move");
  a_byte_copy: assert property (state == bmt_pkg::st_read && mem_rd_ack
                                |=> mem_wr_req && mem_wr_data == $past(mem_rd_data) && mem_wr_addr == dst_cur)
    else $error("written byte differs from read byte");
  a_src_char_stop: assert property (step_done && !src_term_addr[15] && byte_q == src_term_char
                                    |=> state == bmt_pkg::st_idle && $stable(src_cur))
    else $error("source character did not end the move in place");
  a_addr_only_pass: assert property (step_done && src_term_addr[15] && src_cur != src_term_addr[14:0] && !dst_hit
                                     |=> src_cur == $past(src_cur) + 15'h0001 ##1 state == bmt_pkg::st_read)
    else $error("character not ignored with address-only set");
  a_src_addr_stop: assert property (step_done && src_cur == src_term_addr[14:0]
                                    |=> state == bmt_pkg::st_idle && $stable(src_cur) && end_src)
    else $error("source address did not end the move");
  a_dst_char_stop: assert property (step_done && !dst_term_addr[15] && byte_q == dst_term_char
                                    |=> state == bmt_pkg::st_idle && $stable(dst_cur) && end_dst)
    else $error("destination character not found in source stream");
  a_dst_addr_stop: assert property (step_done && dst_cur == dst_term_addr[14:0]
                                    |=> state == bmt_pkg::st_idle && $stable(dst_cur))
    else $error("destination address did not end the move");
  a_end_idle: assert property (end_move |=> state == bmt_pkg::st_idle ##1 !mem_rd_req && !mem_wr_req)
    else $error("move did not end on termination");

  c_move_start: cover property (cmd_go);
  c_end_src: cover property (end_move && src_hit && !dst_hit);
  c_end_dst: cover property (end_move && dst_hit && !src_hit);
  c_irq_idle: cover property (end_move ##[1:4] irq);
endmodule

// *** testbench/bmt_mem_model.sv ***
// byte memory standing behind the controller, prompt or slow
`timescale 1ns/10ps
module bmt_mem_model (
  input wire logic core_clk,
  input wire logic slow,
  input wire logic mem_rd_req,
  input wire logic [14:0] mem_rd_addr,
  output logic mem_rd_ack,
  output logic [7:0] mem_rd_data,
  input wire logic mem_wr_req,
  input wire logic [14:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data,
  output logic mem_wr_ack
);
  logic [7:0] mem [0:32767];
  logic [1:0] wait_cnt;

  initial begin
    mem_rd_ack = 1'b0;
    mem_wr_ack = 1'b0;
    mem_rd_data = 8'h00;
    wait_cnt = 2'h0;
  end

  // plain always: the bench also preloads the array between moves
  always @(posedge core_clk) begin
    mem_rd_ack <= 1'b0;
    mem_wr_ack <= 1'b0;
    // data lines are not held once the byte has been handed over
    mem_rd_data <= ~mem_rd_data;
    if ((mem_rd_req && !mem_rd_ack) || (mem_wr_req && !mem_wr_ack)) begin
      wait_cnt <= wait_cnt + 2'h1;
      if (!slow || wait_cnt == 2'h3) begin
        wait_cnt <= 2'h0;
        if (mem_rd_req) begin
          mem_rd_ack <= 1'b1;
          mem_rd_data <= mem[mem_rd_addr];
        end
        if (mem_wr_req) begin
          mem_wr_ack <= 1'b1;
          mem[mem_wr_addr] <= mem_wr_data;
        end
      end
    end
  end
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the byte move controller
`timescale 1ns/10ps
`include "bmt_consts.svh"
module tb;
  logic core_clk, reset_n, slow, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic mem_rd_req, mem_rd_ack, mem_wr_req, mem_wr_ack;
  logic [14:0] mem_rd_addr, mem_wr_addr;
  logic [7:0] mem_rd_data, mem_wr_data;
  int error_cnt, num_checks, cyc;

  bmt_move_ctrl DUT (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_rd_req,
    .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .mem_wr_req, .mem_wr_addr, .mem_wr_data, .mem_wr_ack, .irq);

  bmt_mem_model u_mem (.core_clk, .slow, .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .mem_wr_req,
    .mem_wr_addr, .mem_wr_data, .mem_wr_ack);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  // programs both sides, starts a move and judges where it stopped
  task automatic move(input logic [14:0] ss, input logic [15:0] st, input logic [7:0] sc, input logic [14:0] ds,
                      input logic [15:0] dt, input logic [7:0] dc, input logic [14:0] es, input logic [14:0] ed,
                      input logic [2:0] est);
    logic [14:0] n;
    int polls;
    reg_wr(`BMT_OFF_SRC_START, {17'h0, ss});
    reg_wr(`BMT_OFF_SRC_TERM_ADDR, {16'h0, st});
    reg_wr(`BMT_OFF_SRC_TERM_CHAR, {24'h0, sc});
    reg_wr(`BMT_OFF_DST_START, {17'h0, ds});
    reg_wr(`BMT_OFF_DST_TERM_ADDR, {16'h0, dt});
    reg_wr(`BMT_OFF_DST_TERM_CHAR, {24'h0, dc});
    reg_wr(`BMT_OFF_CTRL, 32'h1);
    polls = 0;
    do begin
      reg_rd(`BMT_OFF_STATUS, v);
      polls++;
    end while (v[0] !== 1'b0 && polls < 100);
    cmp(v, {29'h0, est});
    reg_rd(`BMT_OFF_SRC_CUR, v);
    cmp(v, {17'h0, es});
    reg_rd(`BMT_OFF_DST_CUR, v);
    cmp(v, {17'h0, ed});
    n = es - ss;
    for (int i = 0; i <= n; i++) begin
      cmp(u_mem.mem[ds + i[14:0]], u_mem.mem[ss + i[14:0]]);
    end
  endtask

  task automatic t_regs;
    cmp(irq, 32'h0);
    reg_rd(`BMT_OFF_STATUS, v);
    cmp(v, 32'h0);
    reg_rd(`BMT_OFF_SRC_CUR, v);
    cmp(v, 32'h0);
    reg_wr(`BMT_OFF_SRC_TERM_CHAR, 32'hffff_ff5a);
    reg_rd(`BMT_OFF_SRC_TERM_CHAR, v);
    cmp(v, 32'h0000_005a);
    // read-only place must ignore the write
    reg_wr(`BMT_OFF_STATUS, 32'hffff_ffff);
    reg_rd(`BMT_OFF_STATUS, v);
    cmp(v, 32'h0);
    reg_rd(8'h30, v);
    cmp(resp, `BMT_RESP_SLVERR);
    cmp(v, 32'h0);
    reg_wr(8'h34, 32'h1);
    cmp(resp, `BMT_RESP_SLVERR);
    $display("register test done");
  endtask

  task automatic t_term;
    for (int i = 0; i < 16; i++) u_mem.mem[15'h100 + i] = 8'h10 + i[7:0];
    u_mem.mem[15'h105] = 8'haa;
    move(15'h100, 16'h010a, 8'haa, 15'h800, 16'h8900, 8'h00, 15'h105, 15'h805, 3'b010);
    move(15'h100, 16'h0103, 8'haa, 15'h800, 16'h8900, 8'h00, 15'h103, 15'h803, 3'b010);
    move(15'h100, 16'h8109, 8'haa, 15'h800, 16'h8900, 8'h00, 15'h109, 15'h809, 3'b010);
    move(15'h100, 16'h8900, 8'h00, 15'h800, 16'h8804, 8'h00, 15'h104, 15'h804, 3'b100);
    $display("termination test done");
  endtask

  task automatic t_irq;
    reg_wr(`BMT_OFF_IRQ_MASK, 32'h1);
    reg_rd(`BMT_OFF_IRQ_STATUS, v);
    cmp(v, 32'h3);
    cmp(irq, 32'h1);
    reg_wr(`BMT_OFF_IRQ_MASK, 32'h2);
    reg_wr(`BMT_OFF_IRQ_STATUS, 32'h2);
    reg_rd(`BMT_OFF_IRQ_STATUS, v);
    cmp(v, 32'h1);
    cmp(irq, 32'h0);
    // both sources unmasked so the busy monitor has something to catch
    reg_wr(`BMT_OFF_IRQ_MASK, 32'h3);
    $display("interrupt test done");
  endtask

  task automatic t_chars;
    logic [7:0] c;
    for (int k = 0; k < 512; k++) begin
      c = k[7:0];
      for (int i = 0; i < 8; i++) u_mem.mem[15'h300 + i] = ~c;
      u_mem.mem[15'h303] = c;
      if (k < 256)
        move(15'h300, 16'h0307, c, 15'h500, 16'h8600, 8'h00, 15'h303, 15'h503, 3'b010);
      else
        move(15'h300, 16'h8400, 8'h00, 15'h500, 16'h0507, c, 15'h303, 15'h503, 3'b100);
    end
    $display("character test done");
  endtask

  task automatic t_addr_bits;
    logic [14:0] t;
    slow <= 1'b1;
    for (int b = 0; b < 15; b++) begin
      t = 15'h1 << b;
      // known bytes, so the copied data can be judged
      for (int i = 0; i < 3; i++) u_mem.mem[t - 15'h2 + i[14:0]] = 8'h40 + i[7:0];
      move(t - 15'h2, {1'b1, t}, 8'h00, 15'h6000, 16'hf000, 8'h00, t, 15'h6002, 3'b010);
    end
    slow <= 1'b0;
    $display("address bit test done");
  endtask

  always @(posedge core_clk) begin
    if (mem_rd_req === 1'b1 || mem_wr_req === 1'b1) cmp(irq, 32'h0);
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      test_done;
    end
  end

  initial begin
    reset_n = 1'b0;
    slow = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    cyc = 0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs;
    t_term;
    t_irq;
    t_chars;
    t_addr_bits;
    test_done;
  end
endmodule
